/* common/ofcc_map.svh */
// register offsets, field positions, reset values and timing counts for the
// output format / crc configuration bank; included by the crc, clock divider and bank modules
`ifndef OFCC_MAP_SVH
`define OFCC_MAP_SVH

// printed offsets are not all multiples of four: indices, byte address = 4*index
`define OFCC_IDX_CONFIG0     4'h0
`define OFCC_IDX_CONFIG1     4'h1
`define OFCC_IDX_STATUS      4'h2
`define OFCC_IDX_OUT_CFG     4'h8
`define OFCC_IDX_OFS_HIGH    4'h9
`define OFCC_IDX_OFS_MID     4'ha
`define OFCC_IDX_OFS_LOW     4'hb
`define OFCC_IDX_GAIN_HIGH   4'hc
`define OFCC_IDX_GAIN_MID    4'hd
`define OFCC_IDX_GAIN_LOW    4'he
`define OFCC_IDX_MAP_CRC     4'hf

`define OFCC_BIT_CLK_SEL     7
`define OFCC_BIT_CLK_DIV     6
`define OFCC_BIT_DRV_SEL     5
`define OFCC_BIT_RESERVED    4
`define OFCC_BIT_RES16       3
`define OFCC_BIT_SER_CRC     2
`define OFCC_BIT_MAP_CRC     1
`define OFCC_BIT_STAT_PFX    0

`define OFCC_BIT_SER_ERR     1
`define OFCC_BIT_MAP_ERR     0

`define OFCC_RST_BYTE        8'h00
`define OFCC_RST_GAIN_HIGH   8'h40
`define OFCC_OUT_CFG_WMASK   8'hef
`define OFCC_CLK_DIV_RATIO   4'h8
`define OFCC_CRC_POLY        8'h07

`endif

/* common/ofcc_pkg.sv */
// types of the output format / crc configuration bank
// assumes ofcc_map.svh sits on the include path
package ofcc_pkg;
  typedef struct packed {
    logic clk_sel;
    logic clk_div;
    logic drive_sel;
    logic reserved;
    logic res16;
    logic ser_crc;
    logic map_crc;
    logic stat_pfx;
  } ofcc_out_cfg_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] data;
  } ofcc_sample_t;

  typedef enum logic [2:0] {
    OFCC_TX_IDLE = 3'b000,
    OFCC_TX_STAT = 3'b001,
    OFCC_TX_DATA = 3'b010,
    OFCC_TX_CRC  = 3'b011
  } ofcc_tx_state_t;
endpackage

/* logic/ofcc_crc8.sv */
// byte-serial crc-8 update, one byte per call of the combinational core
// assumes caller holds the running value in its own register
`timescale 1ns/1ps
`default_nettype none
`include "ofcc_map.svh"
module ofcc_crc8
  import ofcc_pkg::*;
(
  input  wire logic [7:0] crc_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] crc_o
);
  always_comb begin
    logic [7:0] c;
    c = crc_i ^ data_i;
    for (int i = 0; i < 8; i++) begin
      if (c[7]) begin
        c = {c[6:0], 1'b0} ^ `OFCC_CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc_o = c;
  end
endmodule
`default_nettype wire

/* logic/ofcc_clk_div.sv */
// clock-enable generator: internal or external source, optional divide by eight
// assumes ext_tick_i is a one-cycle pulse synchronous to ref_clk_i
`timescale 1ns/1ps
`default_nettype none
`include "ofcc_map.svh"
module ofcc_clk_div
  import ofcc_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic clk_sel_i,
  input  wire logic clk_div_i,
  input  wire logic int_tick_i,
  input  wire logic ext_tick_i,
  output logic      mod_tick_o
);
  logic [3:0] div_cnt;
  logic       ext_use;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !clk_sel_i || !clk_div_i) begin
      div_cnt <= 4'h0;
    end else if (ext_tick_i) begin
      div_cnt <= (div_cnt == `OFCC_CLK_DIV_RATIO - 4'h1) ? 4'h0 : div_cnt + 4'h1;
    end
  end

  // divided tick fires on the eighth external edge
  assign ext_use = clk_div_i ? (ext_tick_i && div_cnt == `OFCC_CLK_DIV_RATIO - 4'h1)
                             : ext_tick_i;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      mod_tick_o <= 1'b0;
    end else begin
      mod_tick_o <= clk_sel_i ? ext_use : int_tick_i;
    end
  end
endmodule
`default_nettype wire

/* logic/ofcc_bank.sv */
// configuration bank: output format, serial and register-map crc, offset correction
// assumes an apb master, a frame source for input bytes and a sample source
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ofcc_map.svh"

// What this block does
// - clock select bit picks internal or external
// - divide bit divides external clock by eight
// - drive select bit gives full or half strength
// - resolution bit picks 24 or 16 bits
// - serial crc on: check input, append output
// - input crc mismatch sets serial error flag
// - writing one clears the serial error flag
// - map crc on: mismatch sets register error
// - prefix bit sends status byte before data
// - three offset registers at 9h, ah, bh
// - offset subtracted as two's complement, before gain
// - map crc off: 0fh is plain scratch
module ofcc_bank
  import ofcc_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        int_tick_i,
  input  wire logic        ext_tick_i,
  output logic             mod_tick_o,
  output logic             half_drive_o,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        rx_last_i,
  input  wire ofcc_sample_t sample_i,
  input  wire logic        tx_ready_i,
  output logic             tx_valid_o,
  output logic      [7:0]  tx_byte_o,
  output logic             tx_last_o
);
  ofcc_out_cfg_t  out_cfg;
  logic [7:0]     cfg0;
  logic [7:0]     cfg1;
  logic [7:0]     ofs_high;
  logic [7:0]     ofs_mid;
  logic [7:0]     ofs_low;
  logic [7:0]     gain_high;
  logic [7:0]     gain_mid;
  logic [7:0]     gain_low;
  logic [7:0]     map_crc;
  logic           ser_err;
  logic           map_err;
  logic           wr_en;
  logic           rd_en;
  logic [3:0]     idx;
  logic           addr_ok;
  logic [7:0]     wbyte;
  logic [7:0]     rd_byte;

  assign idx     = paddr_i[5:2];
  assign addr_ok = (paddr_i[11:6] == 6'h00) && (paddr_i[1:0] == 2'h0) &&
                   (idx <= `OFCC_IDX_CONFIG1 || idx == `OFCC_IDX_STATUS ||
                    idx >= `OFCC_IDX_OUT_CFG);
  // single-cycle access phase; an unmapped address answers with pslverr
  assign pready_o  = 1'b1;
  assign wr_en     = psel_i && penable_i && pwrite_i && addr_ok && pstrb_i[0];
  assign rd_en     = psel_i && !penable_i && !pwrite_i;
  assign pslverr_o = psel_i && penable_i && !addr_ok;
  assign wbyte     = pwdata_i[7:0];

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      out_cfg <= ofcc_out_cfg_t'(`OFCC_RST_BYTE);
    end else if (wr_en && idx == `OFCC_IDX_OUT_CFG) begin
      // reserved bit stays zero
      out_cfg <= ofcc_out_cfg_t'(wbyte & `OFCC_OUT_CFG_WMASK);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cfg0      <= `OFCC_RST_BYTE;
      cfg1      <= `OFCC_RST_BYTE;
      ofs_high  <= `OFCC_RST_BYTE;
      ofs_mid   <= `OFCC_RST_BYTE;
      ofs_low   <= `OFCC_RST_BYTE;
      gain_high <= `OFCC_RST_GAIN_HIGH;
      gain_mid  <= `OFCC_RST_BYTE;
      gain_low  <= `OFCC_RST_BYTE;
      map_crc   <= `OFCC_RST_BYTE;
    end else if (wr_en) begin
      case (idx)
        `OFCC_IDX_CONFIG0:   cfg0 <= wbyte;
        `OFCC_IDX_CONFIG1:   cfg1 <= wbyte;
        `OFCC_IDX_OFS_HIGH:  ofs_high <= wbyte;
        `OFCC_IDX_OFS_MID:   ofs_mid <= wbyte;
        `OFCC_IDX_OFS_LOW:   ofs_low <= wbyte;
        `OFCC_IDX_GAIN_HIGH: gain_high <= wbyte;
        `OFCC_IDX_GAIN_MID:  gain_mid <= wbyte;
        `OFCC_IDX_GAIN_LOW:  gain_low <= wbyte;
        `OFCC_IDX_MAP_CRC:   map_crc <= wbyte;
        default:             ;
      endcase
    end
  end

  always_comb begin
    case (idx)
      `OFCC_IDX_CONFIG0:   rd_byte = cfg0;
      `OFCC_IDX_CONFIG1:   rd_byte = cfg1;
      `OFCC_IDX_STATUS:    rd_byte = {6'h00, ser_err, map_err};
      `OFCC_IDX_OUT_CFG:   rd_byte = out_cfg;
      `OFCC_IDX_OFS_HIGH:  rd_byte = ofs_high;
      `OFCC_IDX_OFS_MID:   rd_byte = ofs_mid;
      `OFCC_IDX_OFS_LOW:   rd_byte = ofs_low;
      `OFCC_IDX_GAIN_HIGH: rd_byte = gain_high;
      `OFCC_IDX_GAIN_MID:  rd_byte = gain_mid;
      `OFCC_IDX_GAIN_LOW:  rd_byte = gain_low;
      `OFCC_IDX_MAP_CRC:   rd_byte = map_crc;
      default:             rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_en) begin
      // setup-phase capture keeps prdata registered yet valid in the access cycle
      prdata_o <= {24'h00_0000, rd_byte};
    end
  end

  // clocking and drive
  ofcc_clk_div u_clk_div (
    .ref_clk_i  (ref_clk_i),
    .reset_i    (reset_i),
    .clk_sel_i  (out_cfg.clk_sel),
    .clk_div_i  (out_cfg.clk_div),
    .int_tick_i (int_tick_i),
    .ext_tick_i (ext_tick_i),
    .mod_tick_o (mod_tick_o)
  );

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      half_drive_o <= 1'b0;
    end else begin
      half_drive_o <= out_cfg.drive_sel;
    end
  end

  // register-map crc, one byte per cycle over 0h-1h and 4h-eh
  logic [3:0] scan_idx;
  logic [7:0] scan_crc;
  logic [7:0] scan_next;
  logic [7:0] scan_byte;
  logic       scan_skip;
  logic       map_mismatch;

  always_comb begin
    case (scan_idx)
      `OFCC_IDX_CONFIG0:   scan_byte = cfg0;
      `OFCC_IDX_CONFIG1:   scan_byte = cfg1;
      `OFCC_IDX_OUT_CFG:   scan_byte = out_cfg;
      `OFCC_IDX_OFS_HIGH:  scan_byte = ofs_high;
      `OFCC_IDX_OFS_MID:   scan_byte = ofs_mid;
      `OFCC_IDX_OFS_LOW:   scan_byte = ofs_low;
      `OFCC_IDX_GAIN_HIGH: scan_byte = gain_high;
      `OFCC_IDX_GAIN_MID:  scan_byte = gain_mid;
      `OFCC_IDX_GAIN_LOW:  scan_byte = gain_low;
      default:             scan_byte = 8'h00;
    endcase
  end
  // 2h and 3h are outside the covered span; 4h-7h lie outside this bank and read zero
  assign scan_skip = (scan_idx == 4'h2) || (scan_idx == 4'h3);

  ofcc_crc8 u_map_crc (
    .crc_i  (scan_crc),
    .data_i (scan_byte),
    .crc_o  (scan_next)
  );

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      scan_idx     <= 4'h0;
      scan_crc     <= 8'h00;
      map_mismatch <= 1'b0;
    end else if (scan_idx == `OFCC_IDX_MAP_CRC) begin
      map_mismatch <= (scan_crc != map_crc);
      scan_idx     <= 4'h0;
      scan_crc     <= 8'h00;
    end else begin
      scan_idx <= scan_idx + 4'h1;
      if (!scan_skip) begin
        scan_crc <= scan_next;
      end
    end
  end

  // input frame crc check
  logic [7:0] rx_crc;
  logic [7:0] rx_next;
  logic       ser_mismatch;

  ofcc_crc8 u_rx_crc (
    .crc_i  (rx_crc),
    .data_i (rx_byte_i),
    .crc_o  (rx_next)
  );

  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !out_cfg.ser_crc) begin
      rx_crc <= 8'h00;
    end else if (rx_valid_i) begin
      rx_crc <= rx_last_i ? 8'h00 : rx_next;
    end
  end
  // last byte of a frame is the sender's crc of the bytes before it
  assign ser_mismatch = out_cfg.ser_crc && rx_valid_i && rx_last_i &&
                        (rx_byte_i != rx_crc);

  // set wins over a simultaneous write-one clear
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ser_err <= 1'b0;
    end else if (ser_mismatch) begin
      ser_err <= 1'b1;
    end else if (wr_en && idx == `OFCC_IDX_STATUS && wbyte[`OFCC_BIT_SER_ERR]) begin
      ser_err <= 1'b0;
    end
  end

  // flag tracks the latest full comparison; off means scratch only
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !out_cfg.map_crc) begin
      map_err <= 1'b0;
    end else if (scan_idx == 4'h0) begin
      map_err <= map_mismatch;
    end
  end

  // offset correction; gain is applied downstream
  logic [23:0] corrected;
  logic [23:0] held;
  logic [1:0]  nbytes;
  logic [1:0]  byte_sel;
  logic [7:0]  tx_crc;
  logic [7:0]  tx_next;
  ofcc_tx_state_t tx_state;
  ofcc_tx_state_t next_tx_state;

  assign corrected = sample_i.data - {ofs_high, ofs_mid, ofs_low};

  ofcc_crc8 u_tx_crc (
    .crc_i  (tx_crc),
    .data_i (tx_byte_o),
    .crc_o  (tx_next)
  );

  always_comb begin
    next_tx_state = tx_state;
    case (tx_state)
      OFCC_TX_IDLE: begin
        if (sample_i.valid) begin
          next_tx_state = out_cfg.stat_pfx ? OFCC_TX_STAT : OFCC_TX_DATA;
        end
      end
      OFCC_TX_STAT: begin
        if (tx_ready_i) begin
          next_tx_state = OFCC_TX_DATA;
        end
      end
      OFCC_TX_DATA: begin
        if (tx_ready_i && byte_sel == nbytes) begin
          next_tx_state = out_cfg.ser_crc ? OFCC_TX_CRC : OFCC_TX_IDLE;
        end
      end
      OFCC_TX_CRC: begin
        if (tx_ready_i) begin
          next_tx_state = OFCC_TX_IDLE;
        end
      end
      default: next_tx_state = OFCC_TX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tx_state <= OFCC_TX_IDLE;
    end else begin
      tx_state <= next_tx_state;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      held     <= 24'h00_0000;
      nbytes   <= 2'h2;
      byte_sel <= 2'h0;
      tx_crc   <= 8'h00;
    end else if (tx_state == OFCC_TX_IDLE && sample_i.valid) begin
      held     <= corrected;
      nbytes   <= out_cfg.res16 ? 2'h1 : 2'h2;
      byte_sel <= 2'h0;
      tx_crc   <= 8'h00;
    end else if (tx_valid_o && tx_ready_i) begin
      tx_crc <= tx_next;
      if (tx_state == OFCC_TX_DATA) begin
        byte_sel <= byte_sel + 2'h1;
      end
    end
  end

  assign tx_valid_o = (tx_state != OFCC_TX_IDLE);
  assign tx_last_o  = (tx_state == OFCC_TX_CRC) ||
                      (tx_state == OFCC_TX_DATA && byte_sel == nbytes && !out_cfg.ser_crc);

  always_comb begin
    case (tx_state)
      OFCC_TX_STAT: tx_byte_o = {6'h00, ser_err, map_err};
      OFCC_TX_DATA: begin
        case (byte_sel)
          2'h0:    tx_byte_o = held[23:16];
          2'h1:    tx_byte_o = held[15:8];
          default: tx_byte_o = held[7:0];
        endcase
      end
      OFCC_TX_CRC:  tx_byte_o = tx_crc;
      default:      tx_byte_o = 8'h00;
    endcase
  end
endmodule
`default_nettype wire

/* test/ofcc_bank_props.sv */
// checker of the output format / crc bank: apb answer, tick source, tx framing
// assumes a bind to ofcc_bank, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module ofcc_bank_props
  import ofcc_pkg::*;
(
  input wire logic         ref_clk_i,
  input wire logic         reset_i,
  input wire logic         psel_i,
  input wire logic         penable_i,
  input wire logic         pwrite_i,
  input wire logic [11:0]  paddr_i,
  input wire logic [31:0]  pwdata_i,
  input wire logic [3:0]   pstrb_i,
  input wire logic [31:0]  prdata_o,
  input wire logic         pready_o,
  input wire logic         pslverr_o,
  input wire logic         int_tick_i,
  input wire logic         ext_tick_i,
  input wire logic         mod_tick_o,
  input wire logic         half_drive_o,
  input wire ofcc_sample_t sample_i,
  input wire logic         tx_ready_i,
  input wire logic         tx_valid_o,
  input wire logic [7:0]   tx_byte_o,
  input wire logic         tx_last_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  wire logic       acc = psel_i && penable_i;
  wire logic [9:0] idx = paddr_i[11:2];
  // two cycles covers both a direct and a re-registered drive output
  property p_drv;
    logic d;
    (acc && pwrite_i && pstrb_i[0] && idx == 10'h008, d = pwdata_i[5])
      |-> ##2 half_drive_o == d;
  endproperty
  a_ready_always: assert property (pready_o) else $error("pready low");
  a_unmapped_err: assert property (acc && idx >= 10'h003 && idx <= 10'h007 |-> pslverr_o)
    else $error("unmapped access not refused");
  a_read_low: assert property (acc && !pwrite_i |-> prdata_o[31:8] == 24'h000000
    && !(idx == 10'h008 && prdata_o[4])) else $error("read data upper or reserved set");
  a_drive_follow: assert property (p_drv) else $error("drive level not written value");
  a_tick_cause: assert property (mod_tick_o |-> $past(int_tick_i) || $past(ext_tick_i))
    else $error("tick without source");
  a_tx_start: assert property (sample_i.valid && !tx_valid_o |=> tx_valid_o)
    else $error("sample not answered");
  a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o)
    && $stable(tx_last_o)) else $error("byte changed while stalled");
  a_frame_end: assert property (tx_valid_o && tx_ready_i && tx_last_o |=> !tx_valid_o)
    else $error("bytes after last");
  c_frame: cover property (tx_valid_o && tx_ready_i && tx_last_o);
  c_refused: cover property (acc && pslverr_o);
  c_tick: cover property (mod_tick_o);
endmodule
`default_nettype wire

/* test/ofcc_host_model.sv */
// far-side serial host: sends input frames with a crc byte, sinks output bytes
// assumes the bank's clock; slow_i makes the sink stall every other cycle
`timescale 1ns/1ps
`default_nettype none
module ofcc_host_model (
  input  wire logic       clk_i,
  input  wire logic       slow_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       tx_last_i,
  output logic            rx_valid_o,
  output logic      [7:0] rx_byte_o,
  output logic            rx_last_o,
  output logic            tx_ready_o
);
  logic [7:0] got[$];
  int         frames = 0;
  initial begin
    rx_valid_o = 1'b0;
    rx_byte_o  = 8'h00;
    rx_last_o  = 1'b0;
    tx_ready_o = 1'b0;
  end
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
    return r;
  endfunction
  task automatic send(input logic [7:0] a, input logic [7:0] b, input logic bad);
    logic [7:0] c;
    c = crc8(crc8(8'h00, a), b) ^ {7'h00, bad};
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_byte_o  <= a;
    @(posedge clk_i);
    rx_byte_o  <= b;
    @(posedge clk_i);
    rx_byte_o  <= c;
    rx_last_o  <= 1'b1;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_last_o  <= 1'b0;
    rx_byte_o  <= ~c;
  endtask
  always @(posedge clk_i) begin
    tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
    if (tx_valid_i && tx_ready_o) begin
      got.push_back(tx_byte_i);
      if (tx_last_i) frames <= frames + 1;
    end
  end
endmodule
`default_nettype wire

/* test/tb_ofcc_bank.sv */
// self-checking bench of the output format / crc bank over apb
// assumes ofcc_host_model as far side and ofcc_bank_props bound to the bank
`timescale 1ns/1ps
`default_nettype none
module tb_ofcc_bank;
  import ofcc_pkg::*;
  logic         ref_clk_i  = 1'b0;
  logic         reset_i    = 1'b1;
  logic         psel_i     = 1'b0;
  logic         penable_i  = 1'b0;
  logic         pwrite_i   = 1'b0;
  logic [11:0]  paddr_i    = 12'h000;
  logic [31:0]  pwdata_i   = 32'h0;
  logic [3:0]   pstrb_i    = 4'h0;
  logic         int_tick_i = 1'b0;
  logic         ext_tick_i = 1'b0;
  logic         slow       = 1'b0;
  ofcc_sample_t sample_i   = '0;
  logic [31:0]  prdata_o;
  logic         pready_o, pslverr_o, mod_tick_o, half_drive_o, rx_valid_i, rx_last_i;
  logic         tx_ready_i, tx_valid_o, tx_last_o;
  logic [7:0]   rx_byte_i, tx_byte_o, c8;
  logic [31:0]  rd;
  logic         er;
  logic [7:0]   cyc = 8'h00;
  logic [7:0]   ex[$];
  logic [7:0]   ck[3] = '{8'h00, 8'h80, 8'hc0};
  int           tk[3] = '{128, 64, 8};
  logic [7:0]   fm[6] = '{8'h00, 8'h08, 8'h01, 8'h04, 8'h0c, 8'h05};
  logic [7:0]   mp[13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'hff, 8'hff,
                           8'hfe, 8'h40, 8'h00, 8'h00};
  int           n;
  int           n_mismatch = 0;
  int           check_count = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc        <= cyc + 8'h01;
    int_tick_i <= ~cyc[0];
    ext_tick_i <= cyc[1:0] == 2'b00;
  end
  ofcc_bank u_dut (.ref_clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .int_tick_i, .ext_tick_i, .mod_tick_o,
    .half_drive_o, .rx_valid_i, .rx_byte_i, .rx_last_i, .sample_i, .tx_ready_i, .tx_valid_o,
    .tx_byte_o, .tx_last_o);
  ofcc_host_model u_host (.clk_i(ref_clk_i), .slow_i(slow), .tx_valid_i(tx_valid_o),
    .tx_byte_i(tx_byte_o), .tx_last_i(tx_last_o), .rx_valid_o(rx_valid_i),
    .rx_byte_o(rx_byte_i), .rx_last_o(rx_last_i), .tx_ready_o(tx_ready_i));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [3:0] ix, input logic [7:0] d);
    @(posedge ref_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    pstrb_i   <= {3'h0, w};
    paddr_i   <= {6'h00, ix, 2'b00};
    pwdata_i  <= {24'h000000, d};
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] ix, input logic [7:0] d);
    apb(1'b1, ix, d);
  endtask
  task automatic rdc(input logic [3:0] ix, input logic [7:0] e);
    apb(1'b0, ix, 8'h00);
    chk(rd, 32'(e));
  endtask
  // output crc covers every byte sent ahead of it, status prefix included
  task automatic frame(input logic [7:0] cfg, input logic [23:0] v, input logic [23:0] ofs);
    logic [23:0] y;
    logic [7:0]  c;
    int          f;
    y = v - ofs;
    c = 8'h00;
    ex = {};
    if (cfg[0]) ex.push_back(8'h00);
    ex.push_back(y[23:16]);
    ex.push_back(y[15:8]);
    if (!cfg[3]) ex.push_back(y[7:0]);
    foreach (ex[i]) c = u_host.crc8(c, ex[i]);
    if (cfg[2]) ex.push_back(c);
    f = u_host.frames;
    wr(4'h8, cfg);
    @(posedge ref_clk_i) sample_i <= '{valid: 1'b1, data: v};
    @(posedge ref_clk_i) sample_i.valid <= 1'b0;
    for (int i = 0; i < 64 && u_host.frames == f; i++) @(posedge ref_clk_i);
    chk(32'(u_host.got.size()), 32'(ex.size()));
    foreach (ex[i]) chk(32'(u_host.got[i]), 32'(ex[i]));
    u_host.got = {};
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_mismatch++;
    test_done;
  end
  initial begin
    repeat (4) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rdc(4'h8, 8'h00);
    rdc(4'h9, 8'h00);
    rdc(4'ha, 8'h00);
    rdc(4'hb, 8'h00);
    rdc(4'hf, 8'h00);
    rdc(4'hc, 8'h40);
    apb(1'b0, 4'h3, 8'h00);
    chk(32'(er), 32'h1);
    wr(4'h8, 8'hff);
    rdc(4'h8, 8'hef);
    chk(32'(half_drive_o), 32'h1);
    $display("test registers done");
    foreach (ck[i]) begin
      wr(4'h8, ck[i]);
      n = 0;
      repeat (8) @(posedge ref_clk_i);
      repeat (256) @(posedge ref_clk_i) n += mod_tick_o;
      chk(32'(n >= tk[i] - 1 && n <= tk[i]), 32'h1);
    end
    chk(32'(half_drive_o), 32'h0);
    $display("test clock done");
    wr(4'h9, 8'hff);
    wr(4'ha, 8'hff);
    wr(4'hb, 8'hfe);
    rdc(4'hb, 8'hfe);
    foreach (fm[i]) begin
      slow <= i[0];
      frame(fm[i], 24'h123456, 24'hfffffe);
    end
    $display("test format done");
    wr(4'h8, 8'h04);
    u_host.send(8'h5a, 8'ha5, 1'b0);
    rdc(4'h2, 8'h00);
    u_host.send(8'h5a, 8'ha5, 1'b1);
    rdc(4'h2, 8'h02);
    wr(4'h2, 8'h02);
    rdc(4'h2, 8'h00);
    wr(4'h8, 8'h00);
    u_host.send(8'h00, 8'hff, 1'b1);
    rdc(4'h2, 8'h00);
    $display("test serial crc done");
    c8 = 8'h00;
    foreach (mp[i]) c8 = u_host.crc8(c8, mp[i]);
    wr(4'h8, 8'h02);
    wr(4'hf, c8);
    repeat (40) @(posedge ref_clk_i);
    rdc(4'h2, 8'h00);
    wr(4'hf, ~c8);
    repeat (40) @(posedge ref_clk_i);
    rdc(4'h2, 8'h01);
    wr(4'h8, 8'h00);
    repeat (40) @(posedge ref_clk_i);
    rdc(4'h2, 8'h00);
    rdc(4'hf, ~c8);
    $display("test map crc done");
    test_done;
  end
endmodule
bind ofcc_bank ofcc_bank_props u_props (.ref_clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .int_tick_i, .ext_tick_i,
  .mod_tick_o, .half_drive_o, .sample_i, .tx_ready_i, .tx_valid_o, .tx_byte_o, .tx_last_o);
`default_nettype wire
